/* File: kss_consts.svh */
// Offsets, field positions, event bits, reset values and matrix size of the keypad status block.
`ifndef KSS_CONSTS_SVH
`define KSS_CONSTS_SVH

// ---------------------------------------------------------------------------
// Register offsets.
// ---------------------------------------------------------------------------
`define KSS_STATUS_OFFS 12'h00c
`define KSS_EVT_OFFS    12'h010
`define KSS_CLR_OFFS    12'h014
`define KSS_EN_OFFS     12'h018

// ---------------------------------------------------------------------------
// Status field positions.
// ---------------------------------------------------------------------------
`define KSS_INT_BIT     21
`define KSS_TKRST_BIT   20
`define KSS_WAKE_BIT    19
`define KSS_TKEY_BIT    18
`define KSS_DBL_BIT     17
`define KSS_SGL_BIT     16
`define KSS_K2R_MSB     14
`define KSS_K2R_LSB     11
`define KSS_K2C_MSB     10
`define KSS_K2C_LSB     8
`define KSS_K1R_MSB     6
`define KSS_K1R_LSB     3
`define KSS_K1C_MSB     2
`define KSS_K1C_LSB     0

// ---------------------------------------------------------------------------
// Event bits, reset values and matrix size.
// ---------------------------------------------------------------------------
`define KSS_EV_CHG      0
`define KSS_EV_TKEY     1
`define KSS_EV_TKRST    2
`define KSS_EV_WAKE     3
`define KSS_EV_W        4
`define KSS_EV_RST      4'h0
`define KSS_EN_RST      4'h0
`define KSS_ROWS        16
`define KSS_COLS        8
`define KSS_KEYS        128
`define KSS_ROWS8_LIM   8
`define KSS_ROWS4_LIM   4

`endif

/* File: kss_keypad_model.sv */
// Behavioural key matrix that hands the block one scan result per request.
`timescale 1ns/1ps

module kss_keypad_model (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             go,
	input  wire logic [127:0]     keys,
	input  wire logic             triple,
	output kss_pkg::kss_scan_type scan
);
	// A result is valid in its done cycle only; the lines toggle otherwise.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan <= '0;
		end else if (go) begin
			scan.matrix     <= keys;
			scan.triple_hit <= triple;
			scan.done       <= 1'b1;
		end else begin
			scan.matrix     <= ~scan.matrix;
			scan.triple_hit <= ~scan.triple_hit;
			scan.done       <= 1'b0;
		end
	end
endmodule

/* File: kss_pkg.sv */
// Types shared by the keypad status block.
package kss_pkg;

	// Number of scanned rows.
	typedef enum logic [1:0] {
		KSS_ROWS16,
		KSS_ROWS8,
		KSS_ROWS4
	} kss_rows_type;

	// One scan result from the scan engine.
	typedef struct packed {
		logic [127:0] matrix;
		logic         done;
		logic         triple_hit;
	} kss_scan_type;

	// Status register fields.
	typedef struct packed {
		logic       key_int;
		logic       triple_key_reset_flag;
		logic       powerdown_wake_flag;
		logic       triple_key_detected;
		logic       double_key_flag;
		logic       single_key_flag;
		logic [3:0] second_key_row;
		logic [2:0] second_key_column;
		logic [3:0] first_key_row;
		logic [2:0] first_key_column;
	} kss_status_type;

	// Whole state of the block.
	typedef struct packed {
		kss_status_type status;
		logic [127:0]   prev_matrix;
		logic [3:0]     evt;
		logic [3:0]     en;
		logic           irq;
		logic [31:0]    prdata;
		logic           pready;
		logic           pslverr;
	} kss_state_type;

endpackage

/* File: kss_status.sv */
// Keypad scan status register with event interrupt over APB.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`include "kss_consts.svh"

module kss_status (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire kss_pkg::kss_scan_type scan,
	input  wire kss_pkg::kss_rows_type rows,
	input  wire logic                  triple_key_reset_enable,
	input  wire logic                  triple_key_reset_event,
	input  wire logic                  keypad_wake_event,
	output logic                       irq
);

	// -----------------------------------------------------------------------
	// Row masking and key search.
	// -----------------------------------------------------------------------

	// State is declared first since the change detect below reads it.
	kss_pkg::kss_state_type s;
	kss_pkg::kss_state_type n;

	logic [127:0] masked;
	logic [6:0]   first_idx;
	logic [6:0]   second_idx;
	logic         first_ok;
	logic         second_ok;
	logic         changed;
	logic         first_hit;
	logic         lower_clear;

	// Rows beyond the configured count never report a key.
	for (genvar r = 0; r < `KSS_ROWS; r++) begin : g_row
		logic row_on;
		assign row_on = (rows == kss_pkg::KSS_ROWS16) ||
			(rows == kss_pkg::KSS_ROWS8 && r < `KSS_ROWS8_LIM) ||
			(rows == kss_pkg::KSS_ROWS4 && r < `KSS_ROWS4_LIM);
		assign masked[r*`KSS_COLS +: `KSS_COLS] =
			scan.matrix[r*`KSS_COLS +: `KSS_COLS] & {`KSS_COLS{row_on}};
	end

	// Walking down from the top leaves the two lowest addresses behind.
	always_comb begin
		first_idx = 7'h00;
		second_idx = 7'h00;
		first_ok = 1'b0;
		second_ok = 1'b0;
		for (int i = `KSS_KEYS - 1; i >= 0; i--) begin
			if (masked[i]) begin
				second_idx = first_idx;
				second_ok = first_ok;
				first_idx = 7'(i);
				first_ok = 1'b1;
			end
		end
	end

	assign changed = scan.done && (masked != s.prev_matrix);

	// Check data: the first key is pressed and no lower key is.
	assign first_hit = masked[first_idx];
	assign lower_clear =
		(masked & ((128'h1 << first_idx) - 128'h1)) == 128'h0;

	// -----------------------------------------------------------------------
	// State and bus decode.
	// -----------------------------------------------------------------------

	logic [31:0]            stat_word;
	logic                   prep;
	logic                   acc;
	logic                   rd_stat;
	logic                   set_int;
	logic [3:0]             ev_set;

	// Request seen in the access phase, answered one cycle later.
	assign prep = psel && penable && !s.pready;
	assign acc = psel && penable && s.pready;
	assign rd_stat = acc && !pwrite && paddr == `KSS_STATUS_OFFS;

	// The three-key event sets key_int only when it does not reset the chip; its event bit latches either way.
	assign set_int = changed ||
		(scan.done && scan.triple_hit && !triple_key_reset_enable);

	// Events that latch into the interrupt status.
	always_comb begin
		ev_set = 4'h0;
		ev_set[`KSS_EV_CHG] = changed;
		ev_set[`KSS_EV_TKEY] = scan.done && scan.triple_hit;
		ev_set[`KSS_EV_TKRST] = triple_key_reset_event;
		ev_set[`KSS_EV_WAKE] = keypad_wake_event;
	end

	// Status word; every bit not named here reads zero.
	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[`KSS_INT_BIT] = s.status.key_int;
		stat_word[`KSS_TKRST_BIT] = s.status.triple_key_reset_flag;
		stat_word[`KSS_WAKE_BIT] = s.status.powerdown_wake_flag;
		stat_word[`KSS_TKEY_BIT] = s.status.triple_key_detected;
		stat_word[`KSS_DBL_BIT] = s.status.double_key_flag;
		stat_word[`KSS_SGL_BIT] = s.status.single_key_flag;
		stat_word[`KSS_K2R_MSB:`KSS_K2R_LSB] = s.status.second_key_row;
		stat_word[`KSS_K2C_MSB:`KSS_K2C_LSB] = s.status.second_key_column;
		stat_word[`KSS_K1R_MSB:`KSS_K1R_LSB] = s.status.first_key_row;
		stat_word[`KSS_K1C_MSB:`KSS_K1C_LSB] = s.status.first_key_column;
	end

	// -----------------------------------------------------------------------
	// Next state.
	// -----------------------------------------------------------------------

	// Clears are applied first so that a same-cycle set always wins.
	always_comb begin
		n = s;
		n.pready = prep;
		n.pslverr = 1'b0;
		if (prep) begin
			n.prdata = 32'h0000_0000;
			case (paddr)
				`KSS_STATUS_OFFS: n.prdata = pwrite ? 32'h0000_0000 : stat_word;
				`KSS_EVT_OFFS:    n.prdata = {28'h0000000, s.evt};
				`KSS_EN_OFFS:     n.prdata = {28'h0000000, s.en};
				`KSS_CLR_OFFS:    n.prdata = 32'h0000_0000;
				default:          n.pslverr = 1'b1;
			endcase
		end
		if (rd_stat) begin
			n.status.key_int = 1'b0;
			n.status.triple_key_reset_flag = 1'b0;
			n.status.powerdown_wake_flag = 1'b0;
		end
		if (acc && pwrite && paddr == `KSS_EN_OFFS) begin
			n.en = pwdata[`KSS_EV_W-1:0];
		end
		if (acc && pwrite && paddr == `KSS_CLR_OFFS) begin
			n.evt = s.evt & ~pwdata[`KSS_EV_W-1:0];
		end
		n.evt = n.evt | ev_set;
		if (scan.done) begin
			n.prev_matrix = masked;
			n.status.triple_key_detected = scan.triple_hit;
			n.status.single_key_flag = first_ok && !second_ok;
			n.status.double_key_flag = second_ok;
			n.status.first_key_row = first_ok ? first_idx[6:3] : 4'h0;
			n.status.first_key_column = first_ok ? first_idx[2:0] : 3'h0;
			n.status.second_key_row = second_ok ? second_idx[6:3] : 4'h0;
			n.status.second_key_column =
				second_ok ? second_idx[2:0] : 3'h0;
		end
		if (set_int) begin
			n.status.key_int = 1'b1;
		end
		if (triple_key_reset_event) begin
			n.status.triple_key_reset_flag = 1'b1;
		end
		if (keypad_wake_event) begin
			n.status.powerdown_wake_flag = 1'b1;
		end
		n.irq = |(n.evt & n.en);
	end

	// -----------------------------------------------------------------------
	// State register and outputs.
	// -----------------------------------------------------------------------

	// All state resets to zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign irq = s.irq;

	// -----------------------------------------------------------------------
	// Checks.
	// -----------------------------------------------------------------------

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_int_on_change: assert property (
		changed |=> s.status.key_int)
		else $error("Key change did not set the key interrupt flag.");

	chk_triple_int: assert property (
		scan.done && scan.triple_hit && !triple_key_reset_enable &&
		!changed |=> s.status.key_int)
		else $error("Three-key event did not set the key interrupt flag.");

	chk_int_read_clear: assert property (
		rd_stat && !set_int |=> !s.status.key_int)
		else $error("Status read did not clear the key interrupt flag.");

	chk_rst_flag_set: assert property (
		triple_key_reset_event |=> s.status.triple_key_reset_flag)
		else $error("Three-key reset flag not set.");

	chk_rst_flag_clear: assert property (
		rd_stat && !triple_key_reset_event |=>
		!s.status.triple_key_reset_flag)
		else $error("Three-key reset flag not cleared by read.");

	chk_wake_flag: assert property (
		keypad_wake_event |=> s.status.powerdown_wake_flag ##1
		(s.status.powerdown_wake_flag || $past(rd_stat)))
		else $error("Wakeup flag not set or dropped unread.");

	chk_triple_det: assert property (
		scan.done |=> s.status.triple_key_detected == $past(scan.triple_hit))
		else $error("Three-key detected flag wrong.");

	chk_double_key: assert property (
		scan.done && $countones(masked) >= 2 |=> s.status.double_key_flag &&
		!s.status.single_key_flag)
		else $error("Double-key flag wrong.");

	chk_single_key: assert property (
		scan.done && $countones(masked) == 1 |=> s.status.single_key_flag &&
		{s.status.first_key_row, s.status.first_key_column} == $past(first_idx))
		else $error("Single-key flag or address wrong.");

	chk_second_key: assert property (
		scan.done && second_ok |=>
		{s.status.second_key_row, s.status.second_key_column} ==
		$past(second_idx))
		else $error("Second key address wrong.");

	chk_lowest_first: assert property (
		scan.done && first_ok |-> first_hit && lower_clear)
		else $error("First key is not the lowest pressed key.");

	chk_row_limit: assert property (
		scan.done && first_ok && rows == kss_pkg::KSS_ROWS4 |=>
		s.status.first_key_row < 4'h4)
		else $error("Key reported beyond the configured rows.");

	chk_reserved_zero: assert property (
		pready && !pslverr && !$past(pwrite) &&
		$past(paddr) == `KSS_STATUS_OFFS |->
		prdata[31:22] == 10'h000 && !prdata[15] && !prdata[7])
		else $error("Reserved status bits read non-zero.");

	chk_apb_answer: assert property (
		psel && penable && !pready |=> pready)
		else $error("APB answer not given in one cycle.");

endmodule

/* File: kss_status_tb.sv */
// Self-checking bench of the keypad status block.
`timescale 1ns/1ps
`include "kss_consts.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
	$display("wrong value at %0t: %h not %h", $time, a, e); end end

module kss_status_tb;
	logic                  pclk, presetn, psel, penable, pwrite, pready;
	logic                  pslverr, irq, tke, tkev, wake, go, triple;
	logic [11:0]           paddr;
	logic [31:0]           pwdata, prdata;
	logic [127:0]          keys;
	kss_pkg::kss_scan_type scan;
	kss_pkg::kss_rows_type rows;
	logic [33:0]           q[$];
	int                    mismatches, n_checks, seed, lim, r;

	kss_keypad_model kp_u (.pclk(pclk), .presetn(presetn), .go(go),
		.keys(keys), .triple(triple), .scan(scan));
	kss_status dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .scan(scan),
		.rows(rows), .triple_key_reset_enable(tke),
		.triple_key_reset_event(tkev), .keypad_wake_event(wake), .irq(irq));

	// Clock of 20 ns period.
	always #10 pclk = ~pclk;

	// Expected status worked out from the keys: first two found, lowest first.
	function automatic logic [31:0] st(logic [127:0] k, int l, logic ki,
		logic tk, logic rf, logic wk);
		int n;
		logic [31:0] s;
		n = 0;
		s = '0;
		for (int i = 0; i < l * 8; i++) if (k[i]) begin
			if (n == 0) s[6:0] = i[6:0];
			if (n == 1) s[14:8] = i[6:0];
			n++;
		end
		s[16] = (n == 1);
		s[17] = (n >= 2);
		s[21:18] = {ki, rf, wk, tk};
		return s;
	endfunction

	// One APB transfer; the expected answer is queued for the monitor.
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [33:0] e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		q.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk iff pready === 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(logic [11:0] a, logic [31:0] d);
		apb(1'b0, a, 32'h0, {2'b10, d});
	endtask

	task automatic wr(logic [11:0] a, logic [31:0] d);
		apb(1'b1, a, d, 34'h0);
	endtask

	// One scan request, then time for the result to land in the status.
	task automatic scan_keys(logic [127:0] k, logic t);
		@(posedge pclk);
		keys <= k;
		triple <= t;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask

	// Compares every answered transfer with the oldest queued note.
	always @(posedge pclk) if (pready === 1'b1) begin
		if (q.size() == 0) begin
			mismatches++;
			$display("wrong value at %0t: unexpected answer", $time);
		end else begin
			logic [33:0] e;
			e = q.pop_front();
			`CHK(pslverr, e[32])
			if (e[33]) `CHK(prdata, e[31:0])
		end
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// Watchdog of 5000 cycles, several times the expected run length.
	initial begin
		#100000;
		mismatches++;
		end_sim();
	end

	initial begin
		{pclk, presetn, psel, penable, pwrite, tke, tkev, wake, go} = '0;
		{triple, paddr, pwdata, keys} = '0;
		rows = kss_pkg::KSS_ROWS16;
		seed = 94;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(`KSS_STATUS_OFFS, 32'h0);
		wr(`KSS_EN_OFFS, 32'hf);
		rd(`KSS_EN_OFFS, 32'hf);
		wr(`KSS_STATUS_OFFS, 32'hffffffff);
		rd(`KSS_STATUS_OFFS, 32'h0);
		apb(1'b1, 12'h020, 32'h1, {2'b01, 32'h0});
		$display("test 1 done");
		keys = '0;
		keys[3] = 1'b1;
		keys[9] = 1'b1;
		scan_keys(keys, 1'b0);
		#1 `CHK(irq, 1'b1)
		rd(`KSS_STATUS_OFFS, st(keys, 16, 1, 0, 0, 0));
		rd(`KSS_STATUS_OFFS, st(keys, 16, 0, 0, 0, 0));
		rd(`KSS_EVT_OFFS, 32'h1);
		wr(`KSS_CLR_OFFS, 32'h1);
		#1 `CHK(irq, 1'b0)
		$display("test 2 done");
		for (int i = 0; i < 9; i++) begin
			rows <= kss_pkg::kss_rows_type'(i % 3);
			lim = (i % 3 == 0) ? 16 : ((i % 3 == 1) ? 8 : 4);
			scan_keys(128'h0, 1'b0);
			apb(1'b0, `KSS_STATUS_OFFS, 32'h0, 34'h0);
			keys = '0;
			r = {$random(seed)} % (lim * 8);
			keys[r] = 1'b1;
			r = {$random(seed)} % 128;
			keys[r] = 1'b1;
			scan_keys(keys, 1'b0);
			rd(`KSS_STATUS_OFFS, st(keys, lim, 1, 0, 0, 0));
		end
		$display("test 3 done");
		rows <= kss_pkg::KSS_ROWS16;
		scan_keys(128'h0, 1'b0);
		apb(1'b0, `KSS_STATUS_OFFS, 32'h0, 34'h0);
		scan_keys(128'h0, 1'b1);
		rd(`KSS_STATUS_OFFS, st(128'h0, 16, 1, 1, 0, 0));
		tke <= 1'b1;
		scan_keys(128'h0, 1'b1);
		rd(`KSS_STATUS_OFFS, st(128'h0, 16, 0, 1, 0, 0));
		$display("test 4 done");
		wr(`KSS_CLR_OFFS, 32'hf);
		wr(`KSS_EN_OFFS, 32'h0);
		@(posedge pclk);
		tkev <= 1'b1;
		wake <= 1'b1;
		@(posedge pclk);
		tkev <= 1'b0;
		wake <= 1'b0;
		repeat (2) @(posedge pclk);
		#1 `CHK(irq, 1'b0)
		rd(`KSS_STATUS_OFFS, st(128'h0, 16, 0, 1, 1, 1));
		rd(`KSS_STATUS_OFFS, st(128'h0, 16, 0, 1, 0, 0));
		wr(`KSS_EN_OFFS, 32'hc);
		#1 `CHK(irq, 1'b1)
		wr(`KSS_CLR_OFFS, 32'hc);
		#1 `CHK(irq, 1'b0)
		$display("test 5 done");
		repeat (3) @(posedge pclk);
		end_sim();
	end
endmodule
